/* vip_pkg.sv */
// vip_pkg: shared constants for the vectored interrupt priority block
package vip_pkg;

  // source ranking: index 0 is the top vector, each step is two bytes lower
  localparam int NUM_SRC = 26;
  localparam int SRC_IDX_W = 5;
  localparam logic [15:0] VEC_TOP = 16'hfffe;
  localparam logic [7:0] VEC_TOP_LO = 8'hfe;
  localparam int NUM_RESET = 3;
  localparam int NUM_NONMASK = 6;

  localparam int SRC_RESET = 0;
  localparam int SRC_CLKMON = 1;
  localparam int SRC_WDOG = 2;
  localparam int SRC_UNIMPL = 3;
  localparam int SRC_SWTRAP = 4;
  localparam int SRC_XREQ = 5;
  localparam int SRC_EXTREQ = 6;
  localparam int SRC_PERIODIC = 7;
  localparam int SRC_CHAN0 = 8;
  localparam int SRC_TOVF = 16;
  localparam int SRC_ACC_OVF = 17;
  localparam int SRC_ACC_EDGE = 18;
  localparam int SRC_SPI = 19;
  localparam int SRC_SCI0 = 20;
  localparam int SRC_SCI1 = 21;
  localparam int SRC_ATD0 = 22;
  localparam int SRC_ATD1 = 23;
  localparam int SRC_PORTJ = 24;
  localparam int SRC_PORTH = 25;

  // elevation value range and reset value
  localparam logic [7:0] PRIO_MAX = 8'hf2;
  localparam logic [7:0] PRIO_MIN = 8'hcc;
  localparam logic [7:0] PRIO_RST = 8'hf2;

  // register byte addresses
  localparam logic [7:0] ADR_PRIO = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h04;
  localparam logic [7:0] ADR_CHAN = 8'h08;
  localparam logic [7:0] ADR_SERIAL = 8'h0c;
  localparam logic [7:0] ADR_PORT = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;

  // control register fields
  localparam int CTL_W = 13;
  localparam int CTL_EXT_EN = 0;
  localparam int CTL_PERIODIC_EN = 1;
  localparam int CTL_SYNC_EN = 2;
  localparam int CTL_CLKMON_EN = 3;
  localparam int CTL_FCLKMON_EN = 4;
  localparam int CTL_WDOG_EN = 5;
  localparam int CTL_TOVF_EN = 6;
  localparam int CTL_ACC_OVF_EN = 7;
  localparam int CTL_ACC_EDGE_EN = 8;
  localparam int CTL_SPI_EN = 9;
  localparam int CTL_SPI_TX_EN = 10;
  localparam int CTL_ATD0_EN = 11;
  localparam int CTL_ATD1_EN = 12;
  localparam logic [12:0] CTRL_RST = 13'h0001;

  // serial register: causes tx empty, tx complete, rx full, idle line
  localparam int SCI1_LSB = 4;
  localparam logic [7:0] SERIAL_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] PORTJ_MASK = 8'hc3;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam int PORTH_LSB = 8;

  // status register fields
  localparam int STAT_EXC_BIT = 16;
  localparam int STAT_RST_BIT = 17;

endpackage : vip_pkg

/* vip_sync2.sv */
// vip_sync2: two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module vip_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // raw and synchronised levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } vip_sync_s;

  vip_sync_s q_r;
  vip_sync_s q_nxt;

  // first stage feeds only the second stage
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.meta = async_in;
    q_nxt.stable = q_r.meta;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      q_r <= '0;
    else if (ce)
      q_r <= q_nxt;
  end

  assign sync_out = q_r.stable;

endmodule : vip_sync2
`default_nettype wire

/* vip_prio_pick.sv */
// vip_prio_pick: fixed-order winner selection with one elevated source
`timescale 1ns/1ps
`default_nettype none
module vip_prio_pick
  import vip_pkg::*;
(
  // eligible requests, index 0 ranks highest
  input wire logic [vip_pkg::NUM_SRC-1:0] elig,
  input wire logic [vip_pkg::SRC_IDX_W-1:0] elev_idx,
  // winner
  output logic [vip_pkg::SRC_IDX_W-1:0] win_idx,
  output logic win_valid
);

  // scan from the bottom so the lowest index is left standing
  always_comb
  begin
    win_idx = '0;
    win_valid = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (elig[i])
      begin
        win_idx = SRC_IDX_W'(i);
        win_valid = 1'b1;
      end
    end
    // elevated source beats every maskable source, never a non-maskable one
    if (elig[elev_idx] && !(|elig[NUM_NONMASK-1:0]))
      win_idx = elev_idx;
  end

endmodule : vip_prio_pick
`default_nettype wire

/* vip_vectored_irq.sv */
// vip_vectored_irq: vectored interrupt and reset source prioritisation
// Functional notes
// - fixed order, reset top down to port H
// - clock monitor and watchdog resets, config-enabled only
// - I-bit masking; priority write elevates one source
// - eight timer channels, own vectors and enables
// - timer overflow vector gated by overflow enable
// - accumulator overflow vector gated by its enable
// - accumulator edge vector gated by its enable
// - each serial port ORs four enabled causes
// - port J four pins, port H eight pins
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vip_vectored_irq
  import vip_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // wishbone classic slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  // external pins, active low, asynchronous
  input wire logic reset_pin_n,
  input wire logic nonmaskable_request_pin_n,
  input wire logic ext_request_pin_n,
  // processor core
  input wire logic cond_x_mask,
  input wire logic cond_i_mask,
  input wire logic unimpl_trap,
  input wire logic software_trap,
  // reset-class failures
  input wire logic clock_monitor_fail,
  input wire logic watchdog_fail,
  // peripheral flags, same clock
  input wire logic sync_pulse,
  input wire logic periodic_flag,
  input wire logic [7:0] chan_flag,
  input wire logic timer_ovf_flag,
  input wire logic acc_ovf_flag,
  input wire logic acc_edge_flag,
  input wire logic spi_flag,
  input wire logic spi_tx_empty,
  input wire logic [3:0] sci0_cause,
  input wire logic [3:0] sci1_cause,
  input wire logic atd0_done,
  input wire logic atd1_done,
  input wire logic [7:0] portj_flag,
  input wire logic [7:0] porth_flag,
  // answer to the core
  output logic exc_req,
  output logic reset_req,
  output logic [15:0] vector_addr
);

  import vip_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [7:0] top_priority_select;
    logic [CTL_W-1:0] ctrl;
    logic [7:0] chan_irq_enable;
    logic [7:0] serial_en;
    logic [7:0] portj_pin_irq_enable;
    logic [7:0] porth_pin_irq_enable;
    logic exc;
    logic rst_req;
    logic [15:0] vec;
  } vip_state_s;

  localparam vip_state_s RST_STATE = '{
    ack: 1'b0, dat: 32'h0000_0000, top_priority_select: PRIO_RST,
    ctrl: CTRL_RST, chan_irq_enable: CHAN_RST, serial_en: SERIAL_RST,
    portj_pin_irq_enable: PORT_RST, porth_pin_irq_enable: PORT_RST,
    exc: 1'b0, rst_req: 1'b0, vec: 16'h0000};

  vip_state_s q_r;
  vip_state_s q_nxt;
  logic [2:0] pin_sync;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] elig;
  logic [SRC_IDX_W-1:0] elev_idx;
  logic [SRC_IDX_W-1:0] win_idx;
  logic win_valid;
  logic [7:0] elev_off;
  logic [31:0] rd_data;
  logic wb_go;
  logic prio_ok;

  // pins are inverted to active high before crossing
  vip_sync2 #(.W(3)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .async_in({~ext_request_pin_n, ~nonmaskable_request_pin_n, ~reset_pin_n}),
    .sync_out(pin_sync)
  );

  // per-channel timer requests, each with its own enable
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_chan
      assign req[SRC_CHAN0 + g] = chan_flag[g] && q_r.chan_irq_enable[g];
    end
  endgenerate

  // reset class and traps: no condition-code masking
  assign req[SRC_RESET] = pin_sync[0];
  assign req[SRC_CLKMON] = clock_monitor_fail
    && (q_r.ctrl[CTL_CLKMON_EN] || q_r.ctrl[CTL_FCLKMON_EN]);
  assign req[SRC_WDOG] = watchdog_fail && q_r.ctrl[CTL_WDOG_EN];
  assign req[SRC_UNIMPL] = unimpl_trap;
  assign req[SRC_SWTRAP] = software_trap;
  // pin request is ungated locally; the sync pulse has its own enable
  assign req[SRC_XREQ] = pin_sync[1] || (sync_pulse && q_r.ctrl[CTL_SYNC_EN]);
  // maskable sources with their local enables
  assign req[SRC_EXTREQ] = pin_sync[2] && q_r.ctrl[CTL_EXT_EN];
  assign req[SRC_PERIODIC] = periodic_flag && q_r.ctrl[CTL_PERIODIC_EN];
  assign req[SRC_TOVF] = timer_ovf_flag && q_r.ctrl[CTL_TOVF_EN];
  assign req[SRC_ACC_OVF] = acc_ovf_flag && q_r.ctrl[CTL_ACC_OVF_EN];
  assign req[SRC_ACC_EDGE] = acc_edge_flag && q_r.ctrl[CTL_ACC_EDGE_EN];
  assign req[SRC_SPI] = (spi_flag && q_r.ctrl[CTL_SPI_EN])
    || (spi_tx_empty && q_r.ctrl[CTL_SPI_TX_EN]);
  assign req[SRC_SCI0] = |(sci0_cause & q_r.serial_en[SCI1_LSB-1:0]);
  assign req[SRC_SCI1] = |(sci1_cause & q_r.serial_en[7:SCI1_LSB]);
  assign req[SRC_ATD0] = atd0_done && q_r.ctrl[CTL_ATD0_EN];
  assign req[SRC_ATD1] = atd1_done && q_r.ctrl[CTL_ATD1_EN];
  assign req[SRC_PORTJ] = |(portj_flag & q_r.portj_pin_irq_enable & PORTJ_MASK);
  assign req[SRC_PORTH] = |(porth_flag & q_r.porth_pin_irq_enable);

  // condition-code masking: X for the shared request, I for external request down to port H
  assign elig[NUM_RESET-1:0] = req[NUM_RESET-1:0];
  assign elig[SRC_UNIMPL] = req[SRC_UNIMPL];
  assign elig[SRC_SWTRAP] = req[SRC_SWTRAP];
  assign elig[SRC_XREQ] = req[SRC_XREQ] && !cond_x_mask;
  assign elig[NUM_SRC-1:NUM_NONMASK] = cond_i_mask ? '0 : req[NUM_SRC-1:NUM_NONMASK];

  // elevated index from the low vector byte; register only holds legal values
  assign elev_off = VEC_TOP_LO - q_r.top_priority_select;
  assign elev_idx = elev_off[SRC_IDX_W:1];

  vip_prio_pick u_pick (
    .elig(elig),
    .elev_idx(elev_idx),
    .win_idx(win_idx),
    .win_valid(win_valid)
  );

  // read mux, unmapped addresses read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (wb_adr)
      ADR_PRIO: rd_data[7:0] = q_r.top_priority_select;
      ADR_CTRL: rd_data[CTL_W-1:0] = q_r.ctrl;
      ADR_CHAN: rd_data[7:0] = q_r.chan_irq_enable;
      ADR_SERIAL: rd_data[7:0] = q_r.serial_en;
      ADR_PORT: rd_data[15:0] = {q_r.porth_pin_irq_enable, q_r.portj_pin_irq_enable};
      ADR_STATUS: rd_data[STAT_RST_BIT:0] = {q_r.rst_req, q_r.exc, q_r.vec};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  assign wb_go = wb_cyc && wb_stb && !q_r.ack;
  // odd or low values would name no source and values above PRIO_MAX a non-maskable one, so they are dropped
  assign prio_ok = !wb_dat_i[0] && wb_dat_i[7:0] >= PRIO_MIN && wb_dat_i[7:0] <= PRIO_MAX;

  // bus answer one cycle after the request; winner registered each cycle
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.ack = wb_go;
    if (wb_go)
    begin
      q_nxt.dat = rd_data;
      if (wb_we)
      begin
        case (wb_adr)
          ADR_PRIO:
          begin
            if (wb_sel[0] && prio_ok)
              q_nxt.top_priority_select = wb_dat_i[7:0];
          end
          ADR_CTRL:
          begin
            if (wb_sel[0])
              q_nxt.ctrl[7:0] = wb_dat_i[7:0];
            if (wb_sel[1])
              q_nxt.ctrl[CTL_W-1:8] = wb_dat_i[CTL_W-1:8];
          end
          ADR_CHAN:
          begin
            if (wb_sel[0])
              q_nxt.chan_irq_enable = wb_dat_i[7:0];
          end
          ADR_SERIAL:
          begin
            if (wb_sel[0])
              q_nxt.serial_en = wb_dat_i[7:0];
          end
          ADR_PORT:
          begin
            if (wb_sel[0])
              q_nxt.portj_pin_irq_enable = wb_dat_i[7:0] & PORTJ_MASK;
            if (wb_sel[1])
              q_nxt.porth_pin_irq_enable = wb_dat_i[PORTH_LSB+7:PORTH_LSB];
          end
          default:
          begin
            q_nxt.dat = rd_data; // status and unmapped writes are ignored
          end
        endcase
      end
    end
    q_nxt.exc = win_valid;
    q_nxt.rst_req = win_valid && (win_idx < SRC_IDX_W'(NUM_RESET));
    q_nxt.vec = win_valid ? VEC_TOP - {10'h000, win_idx, 1'b0} : 16'h0000;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      q_r <= RST_STATE;
    else if (ce)
      q_r <= q_nxt;
  end

  assign wb_ack = q_r.ack;
  assign wb_dat_o = q_r.dat;
  assign exc_req = q_r.exc;
  assign reset_req = q_r.rst_req;
  assign vector_addr = q_r.vec;

  // checks on the registered answer
  property p_reset_top;
    @(posedge ref_clk) disable iff (rst)
    ce && elig[SRC_RESET] |=> exc_req && reset_req && vector_addr == VEC_TOP;
  endproperty
  a_reset_top: assert property (p_reset_top) else $error("reset source not on top vector");

  property p_clkmon_gate;
    @(posedge ref_clk) disable iff (rst)
    ce && !q_r.ctrl[CTL_CLKMON_EN] && !q_r.ctrl[CTL_FCLKMON_EN]
      |=> !(exc_req && vector_addr == 16'hfffc);
  endproperty
  a_clkmon_gate: assert property (p_clkmon_gate) else $error("clock monitor vector while off");

  property p_wdog_vec;
    @(posedge ref_clk) disable iff (rst)
    ce && elig[SRC_WDOG] && !(|elig[1:0]) && !cond_i_mask && !cond_x_mask
      |=> reset_req && vector_addr == 16'hfffa;
  endproperty
  a_wdog_vec: assert property (p_wdog_vec) else $error("watchdog reset not taken");

  property p_xmask;
    @(posedge ref_clk) disable iff (rst)
    ce && cond_x_mask |=> !(exc_req && vector_addr == 16'hfff4);
  endproperty
  a_xmask: assert property (p_xmask) else $error("shared X vector taken while masked");

  property p_imask;
    @(posedge ref_clk) disable iff (rst)
    ce && cond_i_mask |=> !(exc_req && vector_addr <= 16'hfff2);
  endproperty
  a_imask: assert property (p_imask) else $error("maskable vector taken under I mask");

  property p_prio_write;
    @(posedge ref_clk) disable iff (rst)
    ce && wb_go && wb_we && wb_adr == ADR_PRIO && wb_sel[0] && prio_ok
      |=> q_r.top_priority_select == $past(wb_dat_i[7:0]);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority write not stored");

  property p_chan0_gate;
    @(posedge ref_clk) disable iff (rst)
    ce && !q_r.chan_irq_enable[0] |=> !(exc_req && vector_addr == 16'hffee);
  endproperty
  a_chan0_gate: assert property (p_chan0_gate) else $error("channel 0 taken while disabled");

  property p_tovf_gate;
    @(posedge ref_clk) disable iff (rst)
    ce && !q_r.ctrl[CTL_TOVF_EN] |=> !(exc_req && vector_addr == 16'hffde);
  endproperty
  a_tovf_gate: assert property (p_tovf_gate) else $error("overflow taken while disabled");

  property p_acc_gate;
    @(posedge ref_clk) disable iff (rst)
    ce && !q_r.ctrl[CTL_ACC_OVF_EN] && !q_r.ctrl[CTL_ACC_EDGE_EN]
      |=> !(exc_req && (vector_addr == 16'hffdc || vector_addr == 16'hffda));
  endproperty
  a_acc_gate: assert property (p_acc_gate) else $error("accumulator taken while disabled");

  property p_sci_gate;
    @(posedge ref_clk) disable iff (rst)
    ce && q_r.serial_en[SCI1_LSB-1:0] == 4'h0 |=> !(exc_req && vector_addr == 16'hffd6);
  endproperty
  a_sci_gate: assert property (p_sci_gate) else $error("serial 0 taken with no cause on");

  property p_porth_gate;
    @(posedge ref_clk) disable iff (rst)
    ce && q_r.porth_pin_irq_enable == 8'h00 |=> !(exc_req && vector_addr == 16'hffcc);
  endproperty
  a_porth_gate: assert property (p_porth_gate) else $error("port H taken with no pin on");

  property p_elevated_wins;
    @(posedge ref_clk) disable iff (rst)
    ce && elig[elev_idx] && !(|elig[NUM_NONMASK-1:0])
      |=> exc_req && vector_addr == VEC_TOP - {10'h000, $past(elev_idx), 1'b0};
  endproperty
  a_elevated_wins: assert property (p_elevated_wins) else $error("elevated source lost");

  c_reset: cover property (@(posedge ref_clk) disable iff (rst) reset_req && vector_addr == VEC_TOP);
  c_xreq: cover property (@(posedge ref_clk) disable iff (rst) exc_req && vector_addr == 16'hfff4);
  c_porth: cover property (@(posedge ref_clk) disable iff (rst) exc_req && vector_addr == 16'hffcc);
  c_elev: cover property (@(posedge ref_clk) disable iff (rst)
    ce && elig[elev_idx] && elev_idx != SRC_EXTREQ && |elig[SRC_EXTREQ+:1]);

endmodule : vip_vectored_irq
`default_nettype wire

/* vip_core_model.sv */
// vip_core_model: behavioural core that holds the condition mask bits and fetches vectors
`timescale 1ns/1ps
`default_nettype none
module vip_core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // mask commands from the program under test
  input wire logic set_i_mask,
  input wire logic set_x_mask,
  // answer from the block
  input wire logic exc_req,
  input wire logic [15:0] vector_addr,
  // condition bits and last fetched vector
  output logic cond_x_mask,
  output logic cond_i_mask,
  output logic [15:0] fetched_vec
);
  // masks come up set out of reset, as a real core leaves them, so nothing
  // maskable gets through until the program clears them
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cond_x_mask <= 1'b1;
      cond_i_mask <= 1'b1;
      fetched_vec <= 16'h0000;
    end
    else
    begin
      cond_x_mask <= set_x_mask;
      cond_i_mask <= set_i_mask;
      if (exc_req)
        fetched_vec <= vector_addr;
    end
  end
endmodule : vip_core_model
`default_nettype wire

/* test_vip_vectored_irq.sv */
// test_vip_vectored_irq: register and priority tests for the vectored interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_vip_vectored_irq;
  import vip_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic reset_pin_n = 1'b1, nonmaskable_request_pin_n = 1'b1, ext_request_pin_n = 1'b1;
  logic cond_x_mask, cond_i_mask, set_i_mask = 1'b1, set_x_mask = 1'b1;
  logic unimpl_trap = 1'b0, software_trap = 1'b0, clock_monitor_fail = 1'b0;
  logic watchdog_fail = 1'b0, sync_pulse = 1'b0, periodic_flag = 1'b0;
  logic timer_ovf_flag = 1'b0, acc_ovf_flag = 1'b0, acc_edge_flag = 1'b0;
  logic spi_flag = 1'b0, spi_tx_empty = 1'b0, atd0_done = 1'b0, atd1_done = 1'b0;
  logic [7:0] chan_flag = 8'h00, portj_flag = 8'h00, porth_flag = 8'h00;
  logic [3:0] sci0_cause = 4'h0, sci1_cause = 4'h0;
  logic exc_req, reset_req;
  logic [15:0] vector_addr, fetched_vec;
  int errors = 0, compares = 0;
  logic [7:0] zero_adr [5] = '{ADR_CHAN, ADR_SERIAL, ADR_PORT, ADR_STATUS, 8'h40};
  // -1 marks a pin whose enable is not kept, so nothing may be raised
  int exp_idx [21] = '{SRC_TOVF, SRC_ACC_OVF, SRC_ACC_EDGE, SRC_SCI0, SRC_SCI0, SRC_SCI0,
    SRC_SCI0, SRC_SCI1, SRC_SCI1, SRC_SCI1, SRC_SCI1, SRC_PORTH, SRC_PORTJ, SRC_PERIODIC,
    SRC_SPI, SRC_ATD0, SRC_ATD1, SRC_SPI, -1, SRC_CLKMON, SRC_XREQ};

  vip_vectored_irq vip_vectored_irq_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .reset_pin_n(reset_pin_n),
    .nonmaskable_request_pin_n(nonmaskable_request_pin_n),
    .ext_request_pin_n(ext_request_pin_n), .cond_x_mask(cond_x_mask),
    .cond_i_mask(cond_i_mask), .unimpl_trap(unimpl_trap), .software_trap(software_trap),
    .clock_monitor_fail(clock_monitor_fail), .watchdog_fail(watchdog_fail),
    .sync_pulse(sync_pulse), .periodic_flag(periodic_flag), .chan_flag(chan_flag),
    .timer_ovf_flag(timer_ovf_flag), .acc_ovf_flag(acc_ovf_flag),
    .acc_edge_flag(acc_edge_flag), .spi_flag(spi_flag), .spi_tx_empty(spi_tx_empty),
    .sci0_cause(sci0_cause), .sci1_cause(sci1_cause), .atd0_done(atd0_done),
    .atd1_done(atd1_done), .portj_flag(portj_flag), .porth_flag(porth_flag),
    .exc_req(exc_req), .reset_req(reset_req), .vector_addr(vector_addr));

  vip_core_model vip_core_model_inst (.ref_clk(ref_clk), .rst(rst),
    .set_i_mask(set_i_mask), .set_x_mask(set_x_mask), .exc_req(exc_req),
    .vector_addr(vector_addr), .cond_x_mask(cond_x_mask), .cond_i_mask(cond_i_mask),
    .fetched_vec(fetched_vec));

  // free-running bus clock
  always #5 ref_clk = ~ref_clk;

  task print_verdict;
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; the wait is bounded so a dead slave ends the run
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_i <= dat;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1)
    begin
      errors++;
      print_verdict();
    end
  endtask : wb

  task settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  function automatic logic [15:0] vec(input int idx);
    return (idx < 0) ? 16'h0000 : VEC_TOP - 16'(2 * idx);
  endfunction : vec

  task expect_vec(input logic [15:0] v);
    settle(2);
    check({31'h0, exc_req}, {31'h0, v != 16'h0000});
    check({16'h0, vector_addr}, {16'h0, v});
  endtask : expect_vec

  task clear_all;
    @(posedge ref_clk);
    {sync_pulse, periodic_flag, timer_ovf_flag, acc_ovf_flag, acc_edge_flag, spi_flag,
      spi_tx_empty, atd0_done, atd1_done, unimpl_trap, software_trap} <= '0;
    {clock_monitor_fail, watchdog_fail, chan_flag, sci0_cause, sci1_cause} <= '0;
    {portj_flag, porth_flag} <= '0;
    {reset_pin_n, nonmaskable_request_pin_n, ext_request_pin_n} <= 3'b111;
  endtask : clear_all

  // drives one source line picked by number; 19 and 20 are the clock monitor and sync pulse
  task put(input int k, input logic v);
    case (k)
      0: timer_ovf_flag <= v;
      1: acc_ovf_flag <= v;
      2: acc_edge_flag <= v;
      3, 4, 5, 6: sci0_cause[k-3] <= v;
      7, 8, 9, 10: sci1_cause[k-7] <= v;
      11: porth_flag[5] <= v;
      12: portj_flag[7] <= v;
      13: periodic_flag <= v;
      14: spi_flag <= v;
      15: atd0_done <= v;
      16: atd1_done <= v;
      17: spi_tx_empty <= v;
      19: clock_monitor_fail <= v;
      20: sync_pulse <= v;
      default: portj_flag[2] <= v;
    endcase
  endtask : put

  // hang guard
  initial
  begin
    #300000;
    errors++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b0, ADR_PRIO, 32'h0);
    check(rd, {24'h0, PRIO_RST});
    wb(1'b0, ADR_CTRL, 32'h0);
    check(rd, {19'h0, CTRL_RST});
    for (int a = 0; a < 5; a++)
    begin
      wb(1'b0, zero_adr[a], 32'h0);
      check(rd, 32'h0);
    end
    wb(1'b1, ADR_CHAN, 32'h000000ff);
    wb(1'b1, ADR_CTRL, 32'h00001fff);
    wb(1'b1, ADR_SERIAL, 32'h000000ff);
    wb(1'b1, ADR_PORT, 32'h0000ffff);
    wb(1'b0, ADR_PORT, 32'h0);
    check(rd, 32'h0000ffc3);
    @(posedge ref_clk);
    chan_flag <= 8'h01;
    expect_vec(16'h0000);
    @(posedge ref_clk);
    set_i_mask <= 1'b0;
    set_x_mask <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      chan_flag <= 8'(1 << i);
      expect_vec(vec(SRC_CHAN0 + i));
      check({16'h0, fetched_vec}, {16'h0, vec(SRC_CHAN0 + i)});
    end
    @(posedge ref_clk);
    chan_flag <= 8'h81;
    expect_vec(vec(SRC_CHAN0));
    wb(1'b1, ADR_PRIO, 32'h000000e0);
    expect_vec(vec(SRC_CHAN0 + 7));
    wb(1'b1, ADR_PRIO, 32'h000000e1);
    wb(1'b1, ADR_PRIO, 32'h000000f4);
    wb(1'b0, ADR_PRIO, 32'h0);
    check(rd, 32'h000000e0);
    @(posedge ref_clk);
    set_i_mask <= 1'b1;
    expect_vec(16'h0000);
    @(posedge ref_clk);
    sync_pulse <= 1'b1;
    expect_vec(vec(SRC_XREQ));
    wb(1'b0, ADR_STATUS, 32'h0);
    check(rd, {14'h0, 1'b0, 1'b1, vec(SRC_XREQ)});
    @(posedge ref_clk);
    set_x_mask <= 1'b1;
    expect_vec(16'h0000);
    // unmaskable sources, each outranking the one before
    @(posedge ref_clk);
    software_trap <= 1'b1;
    expect_vec(vec(SRC_SWTRAP));
    @(posedge ref_clk);
    unimpl_trap <= 1'b1;
    expect_vec(vec(SRC_UNIMPL));
    @(posedge ref_clk);
    watchdog_fail <= 1'b1;
    expect_vec(vec(SRC_WDOG));
    check({31'h0, reset_req}, 32'h1);
    @(posedge ref_clk);
    clock_monitor_fail <= 1'b1;
    expect_vec(vec(SRC_CLKMON));
    @(posedge ref_clk);
    reset_pin_n <= 1'b0;
    settle(2);
    expect_vec(vec(SRC_RESET));
    @(posedge ref_clk);
    reset_pin_n <= 1'b1;
    clock_monitor_fail <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h00001fdf);
    expect_vec(vec(SRC_UNIMPL));
    check({31'h0, reset_req}, 32'h0);
    clear_all();
    wb(1'b1, ADR_CTRL, 32'h00001fff);
    @(posedge ref_clk);
    set_i_mask <= 1'b0;
    set_x_mask <= 1'b0;
    // the last two lines also prove the config and sync-pulse gates open
    for (int k = 0; k < 21; k++)
    begin
      @(posedge ref_clk);
      put(k, 1'b1);
      expect_vec(vec(exp_idx[k]));
      @(posedge ref_clk);
      put(k, 1'b0);
    end
    @(posedge ref_clk);
    ext_request_pin_n <= 1'b0;
    settle(2);
    expect_vec(vec(SRC_EXTREQ));
    @(posedge ref_clk);
    nonmaskable_request_pin_n <= 1'b0;
    settle(2);
    expect_vec(vec(SRC_XREQ));
    // clock enable low must freeze the answer even when a higher source arrives
    @(posedge ref_clk);
    ce <= 1'b0;
    software_trap <= 1'b1;
    expect_vec(vec(SRC_XREQ));
    @(posedge ref_clk);
    ce <= 1'b1;
    expect_vec(vec(SRC_SWTRAP));
    clear_all();
    wb(1'b1, ADR_CTRL, 32'h0);
    wb(1'b1, ADR_SERIAL, 32'h0);
    wb(1'b1, ADR_PORT, 32'h0);
    // with the control, serial and port enables off, clock monitor and sync pulse must stay silent too
    for (int k = 0; k < 21; k++)
    begin
      @(posedge ref_clk);
      put(k, 1'b1);
      expect_vec(16'h0000);
      @(posedge ref_clk);
      put(k, 1'b0);
    end
    print_verdict();
  end
endmodule : test_vip_vectored_irq
`default_nettype wire
